/* File: rtl/io_port_bank.sv */
// programmable i/o port bank with apb register access
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/10ps
module io_port_bank #(
  parameter int NUM_PORTS = io_port_pkg::NUM_PORTS
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [io_port_pkg::NUM_BITS-1:0] pin_in,
  output logic [io_port_pkg::NUM_BITS-1:0] pin_out,
  output logic [io_port_pkg::NUM_BITS-1:0] pin_oe,
  output logic [io_port_pkg::NUM_BITS-1:0] pin_pullup,
  input wire logic [io_port_pkg::NUM_BITS-1:0] periph_oe,
  input wire logic [io_port_pkg::NUM_BITS-1:0] periph_out,
  output logic [io_port_pkg::NUM_DAC-1:0] dac_out_en
);
  // every port keeps eight bits, connected to a pin or not, so software
  // sees one uniform map; the pull-up groups cover the same span in fours
  localparam int NB = io_port_pkg::NUM_BITS;
  localparam int NP = io_port_pkg::NUM_PU;

  logic [NB-1:0] dir;
  logic [NB-1:0] latch;
  logic [NP-1:0] pu_en;
  logic [io_port_pkg::NUM_DAC-1:0] dac_en;
  logic [NB-1:0] dac_pin;
  logic setup_rd;
  logic access_wr;
  logic [31:0] next_prdata;
  logic next_slverr;
  logic [3:0] port_idx;
  logic dir_hit;
  logic data_hit;

  // apb strobes; no wait states, pready is high for one cycle in the access phase
  assign access_wr = psel && penable && pwrite;
  assign setup_rd = psel && !penable;
  assign data_hit = paddr < io_port_pkg::PORT_SPAN && paddr[1:0] == 2'h0;
  assign dir_hit = paddr >= io_port_pkg::DIR_BASE
    && paddr < (io_port_pkg::DIR_BASE + io_port_pkg::PORT_SPAN) && paddr[1:0] == 2'h0;
  // both windows sit on 64-byte boundaries, so bits 5:2 pick the port
  assign port_idx = paddr[5:2];

  // dac channel pin map
  always_comb begin
    dac_pin = '0;
    dac_pin[io_port_pkg::DAC0_BIT] = dac_en[0];
    dac_pin[io_port_pkg::DAC1_BIT] = dac_en[1];
  end

  // pin ownership: a peripheral drives its pin, except on a live dac channel,
  // where the analog level must not be fought by a digital driver
  logic [NB-1:0] periph_owns;
  assign periph_owns = periph_oe & ~dac_pin;

  // direction bits, one per pin, all reset to input
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dir <= '0;
    end else if (access_wr && dir_hit) begin
      dir[port_idx*8 +: 8] <= pwdata[7:0];
    end
  end

  // output latches, also held for unconnected bits; writing the latch of an
  // input pin is harmless and lets software preload before turning it around
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      latch <= '0;
    end else if (access_wr && data_hit) begin
      latch[port_idx*8 +: 8] <= pwdata[7:0];
    end
  end

  // pull-up groups, eleven per word; the upper word starts at group eleven
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pu_en <= io_port_pkg::PU_RESET;
    end else if (access_wr && paddr == io_port_pkg::PU_LO_OFFS) begin
      pu_en[NP/2-1:0] <= pwdata[NP/2-1:0];
    end else if (access_wr && paddr == io_port_pkg::PU_HI_OFFS) begin
      pu_en[NP-1:NP/2] <= pwdata[NP-NP/2-1:0];
    end
  end

  // dac output enables only; the converters themselves live elsewhere
  // limitation: a set direction bit still drives a dac pin, software must not
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dac_en <= io_port_pkg::DAC_CTL_RESET;
    end else if (access_wr && paddr == io_port_pkg::DAC_CTL_OFFS) begin
      dac_en <= pwdata[1:0];
    end
  end

  // read mux; data reads return the pin, not the latch, so a pin held
  // by an outside source shows that source even while it is an output;
  // reading the latch back would hide a shorted or overloaded line
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    if (data_hit) begin
      next_prdata[7:0] = pin_in[port_idx*8 +: 8];
    end else if (dir_hit) begin
      next_prdata[7:0] = dir[port_idx*8 +: 8];
      next_prdata[io_port_pkg::INPUT_ONLY_BIT % 8] =
        (port_idx == 4'(io_port_pkg::INPUT_ONLY_BIT / 8)) ? 1'b0
        : dir[port_idx*8 + io_port_pkg::INPUT_ONLY_BIT % 8];
    end else if (paddr == io_port_pkg::PU_LO_OFFS) begin
      next_prdata[NP/2-1:0] = pu_en[NP/2-1:0];
    end else if (paddr == io_port_pkg::PU_HI_OFFS) begin
      next_prdata[NP-NP/2-1:0] = pu_en[NP-1:NP/2];
    end else if (paddr == io_port_pkg::DAC_CTL_OFFS) begin
      next_prdata[1:0] = dac_en;
    end else begin
      next_slverr = 1'b1; // unmapped address
    end
  end

  // bus answer registered in setup, valid through access; this costs no
  // wait state and keeps prdata a flop at the cost of decoding in setup
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= setup_rd;
      if (setup_rd) begin
        prdata <= pwrite ? 32'h0000_0000 : next_prdata;
        pslverr <= next_slverr;
      end
    end
  end

  // pin drivers; registered so every output is a flop, one process per concern
  genvar i;
  generate
    for (i = 0; i < NB; i++) begin : g_pin
      if (i == io_port_pkg::INPUT_ONLY_BIT) begin : g_in_only
        // the input-only line has no driver, whatever software writes
        always_ff @(posedge mclk or negedge rst_n) begin
          if (!rst_n) begin
            pin_oe[i] <= 1'b0;
            pin_out[i] <= 1'b0;
          end else begin
            pin_oe[i] <= 1'b0;
            pin_out[i] <= 1'b0;
          end
        end
        // never an output, so its group pull-up always applies
        always_ff @(posedge mclk or negedge rst_n) begin
          if (!rst_n) begin
            pin_pullup[i] <= 1'b0;
          end else begin
            pin_pullup[i] <= pu_en[i/4];
          end
        end
      end else begin : g_io
        // output enable: a peripheral output wins over the direction bit
        always_ff @(posedge mclk or negedge rst_n) begin
          if (!rst_n) begin
            pin_oe[i] <= 1'b0;
          end else begin
            pin_oe[i] <= periph_owns[i] || dir[i];
          end
        end
        // drive value follows the same owner as the enable
        always_ff @(posedge mclk or negedge rst_n) begin
          if (!rst_n) begin
            pin_out[i] <= 1'b0;
          end else begin
            pin_out[i] <= periph_owns[i] ? periph_out[i] : latch[i];
          end
        end
        // pull-up only for a true input; a live dac channel forces it off
        always_ff @(posedge mclk or negedge rst_n) begin
          if (!rst_n) begin
            pin_pullup[i] <= 1'b0;
          end else begin
            pin_pullup[i] <= pu_en[i/4] && !dir[i] && !periph_oe[i]
              && !dac_pin[i];
          end
        end
      end
    end
  endgenerate

  // enables are echoed from a flop so the analog side sees a clean level

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dac_out_en <= io_port_pkg::DAC_CTL_RESET;
    end else begin
      dac_out_en <= dac_en;
    end
  end
endmodule : io_port_bank

/* File: rtl/io_port_pkg.sv */
// constants for the programmable i/o port bank
package io_port_pkg;
  localparam int NUM_PORTS = 11;
  localparam int PORT_W = 8;
  localparam int NUM_BITS = NUM_PORTS * PORT_W;
  localparam int NUM_PU = NUM_BITS / 4;
  localparam int NUM_DAC = 2;
  // input-only line: port 8 bit 5
  localparam int INPUT_ONLY_BIT = 69;
  // dac channels ride on port 9 bits 3 and 4
  localparam int DAC0_BIT = 75;
  localparam int DAC1_BIT = 76;
  // register map, one word each; ports at base + 4*port
  localparam logic [11:0] DATA_BASE = 12'h000;
  localparam logic [11:0] DIR_BASE = 12'h040;
  localparam logic [11:0] PU_LO_OFFS = 12'h080;
  localparam logic [11:0] PU_HI_OFFS = 12'h084;
  localparam logic [11:0] DAC_CTL_OFFS = 12'h088;
  localparam logic [11:0] PORT_SPAN = 12'h02C;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [NUM_PU-1:0] PU_RESET = '0;
  localparam logic [1:0] DAC_CTL_RESET = 2'h0;
endpackage : io_port_pkg

/* File: tb/io_port_bank_checker.sv */
// assertions on the port bank's apb answer and pin outputs
`timescale 1ns/10ps
module io_port_bank_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [87:0] pin_out,
  input wire logic [87:0] pin_oe,
  input wire logic [87:0] pin_pullup,
  input wire logic [87:0] periph_oe,
  input wire logic [87:0] periph_out,
  input wire logic [1:0] dac_out_en
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_ready_next: assert property (psel && !penable |=> pready) else $error("pready late");
  a_ready_access: assert property (pready |-> psel && penable) else $error("pready stray");
  a_unmapped_err: assert property (psel && !penable && paddr == 12'hFFC |=> pslverr)
    else $error("no pslverr");
  a_input_hiz: assert property (!pin_oe[69]) else $error("input line driven");
  a_oe_reset: assert property ($rose(rst_n) |-> pin_oe == '0) else $error("oe after reset");
  a_periph_wins: assert property (periph_oe[0] |=> pin_oe[0] && pin_out[0] == $past(periph_out[0]))
    else $error("periph not driven");
  a_pull_off_out: assert property (pin_oe[0] |-> !pin_pullup[0]) else $error("pullup on out");
  a_dac_no_pull: assert property (dac_out_en[0] |=> !pin_pullup[75]) else $error("dac pullup");
endmodule : io_port_bank_checker
bind io_port_bank io_port_bank_checker chk (.mclk, .rst_n, .psel, .penable, .paddr, .pready,
  .pslverr, .pin_out, .pin_oe, .pin_pullup, .periph_oe, .periph_out, .dac_out_en);

/* File: tb/pin_model.sv */
// outside circuits on the pins: a source where enabled, else the pull-up, else ground
`timescale 1ns/10ps
module pin_model (
  input wire logic [87:0] pin_out,
  input wire logic [87:0] pin_oe,
  input wire logic [87:0] pin_pullup,
  input wire logic [87:0] ext_en,
  input wire logic [87:0] ext_val,
  output logic [87:0] pin_in
);
  // device drive wins; an undriven line takes the outside source where enabled, else its pull-up, else ground
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val) | (~ext_en & pin_pullup)));
endmodule : pin_model

/* File: tb/tb_top.sv */
// testbench for the port bank: apb accesses and pin checks
`timescale 1ns/10ps
module tb_top;
  logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [87:0] pin_in, pin_out, pin_oe, pin_pullup, periph_oe = '0, periph_out = '0;
  logic [87:0] ext_en = '1, ext_val = 88'h5A;
  logic [1:0] dac_out_en;
  int mismatches = 0, tests_run = 0;
  initial forever #25 mclk = ~mclk;
  io_port_bank dut (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pin_in, .pin_out, .pin_oe, .pin_pullup, .periph_oe, .periph_out, .dac_out_en);
  pin_model ext (.pin_out, .pin_oe, .pin_pullup, .ext_en, .ext_val, .pin_in);
  task automatic report_and_stop;
    if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge mclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) chk("timeout", 0, 1);
    if (pready !== 1'b1) report_and_stop;
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb
  // pins follow registers one cycle late; two edges cover it
  task automatic settle;
    repeat (2) @(posedge mclk);
  endtask : settle
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1;
    apb(0, 12'h040, 0);
    chk("dir0", 0, rd);
    apb(1, 12'h040, 32'hA5);
    apb(1, 12'h000, 32'h3C);
    apb(1, 12'h080, 32'h1);
    settle;
    chk("oe0", 32'hA5, pin_oe[7:0]);
    chk("out0", 32'h24, pin_out[7:0] & 8'hA5);
    chk("pull0", 32'h0A, pin_pullup[7:0]);
    apb(0, 12'h000, 0);
    chk("data0", 32'h7E, rd);
    apb(1, 12'h060, 32'hFF);
    apb(0, 12'h060, 0);
    chk("dir8", 32'hDF, rd);
    apb(1, 12'h044, 32'hFF);
    apb(0, 12'h044, 0);
    chk("dir1", 32'hFF, rd);
    periph_oe <= 88'h10001;
    periph_out <= 88'h10001;
    apb(1, 12'h084, 32'h80);
    settle;
    chk("periph", 32'h3, {pin_oe[16], pin_out[16]});
    chk("pull75", 32'h1, pin_pullup[75]);
    apb(1, 12'h088, 32'h3);
    settle;
    chk("dac", 32'hC, {dac_out_en, pin_pullup[76:75]});
    apb(0, 12'hFFC, 0);
    chk("slverr", 32'h1, err);
    report_and_stop;
  end
endmodule : tb_top
